/* File: common/boot_pkg.sv */
/*
 Shared constants and carrier types for the boot configuration controller.
 Assumes one 25 MHz clock and a synchronous, active-high reset.
*/
package boot_pkg;
	// Boot mode strap encoding
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_HOST = 2'h1;
	localparam logic [1:0] MODE_ROM = 2'h2;
	// ROM image geometry
	localparam int ROM_BYTES = 1024;
	localparam int WORD_BYTES = 4;
	localparam int ROM_WORDS = ROM_BYTES / WORD_BYTES;
	localparam int BYTE_AW = 10;
	localparam int WORD_AW = 8;
	// Execution start address
	localparam logic [31:0] START_ADDR = 32'h0000_0000;
	// Byte offset of the image inside chip_enable_space_one
	localparam logic [BYTE_AW-1:0] ROM_BASE = 10'h000;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_HOST_WAIT,
		ST_ROM_READ,
		ST_ROM_WAIT,
		ST_ROM_WRITE,
		ST_RUN
	} boot_state_t;

	// Byte read request towards the ROM on the memory interface
	typedef struct packed {
		logic req;
		logic [BYTE_AW-1:0] addr;
	} rom_req_t;

	// Word write towards internal memory
	typedef struct packed {
		logic we;
		logic [WORD_AW-1:0] addr;
		logic [31:0] data;
	} mem_wr_t;

	// Straps captured at reset release
	typedef struct packed {
		logic [1:0] mode;
		logic pci_sel;
	} straps_t;
endpackage

/* File: rtl/boot_mode_controller.sv */
/*
 Boot configuration controller: holds the CPU stalled after reset and
 releases it per boot mode (host load, ROM copy, or direct execution).
 Assumes the ROM answers each byte read with a one-cycle rom_valid, the
 memory accepts a word write every cycle, and straps are stable at reset.
*/
`timescale 1ns/100ps

module boot_mode_controller #(
	parameter bit HAS_PCI = 1'b1,
	parameter bit BIG_ENDIAN = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] boot_mode,
	input wire logic pci_strap,
	input wire logic host_int_set,
	input wire logic cpu_int_clear,
	input wire logic rom_valid,
	input wire logic [7:0] rom_data,
	output boot_pkg::rom_req_t rom_req,
	output boot_pkg::mem_wr_t mem_wr,
	output logic cpu_stall,
	output logic [31:0] cpu_start_addr,
	output logic host_port_en,
	output logic pci_boot_en,
	output logic host_int_bit,
	output logic cpu_int_pending,
	output logic boot_done
);
	boot_pkg::boot_state_t state, next_state;
	boot_pkg::straps_t straps, next_straps;
	boot_pkg::rom_req_t next_rom_req;
	boot_pkg::mem_wr_t next_mem_wr;
	logic [boot_pkg::BYTE_AW-1:0] byte_cnt, next_byte_cnt;
	logic [23:0] pack, next_pack;
	logic next_stall, next_host_port_en, next_pci_boot_en;
	logic next_host_int_bit, next_int_pending, next_boot_done;

	// Builds a word from three packed bytes and the last byte per the system byte order
	function automatic logic [31:0] pack_word(input logic [23:0] lo,
		input logic [7:0] last);
		if (BIG_ENDIAN)
			pack_word = {lo, last};
		else
			pack_word = {last, lo[7:0], lo[15:8], lo[23:16]};
	endfunction

	// Boot sequencing, strap capture and interrupt bit handling
	always_comb
	begin
		next_state = state;
		next_straps = straps;
		next_rom_req = rom_req;
		next_mem_wr = mem_wr;
		next_byte_cnt = byte_cnt;
		next_pack = pack;
		next_stall = cpu_stall;
		next_host_port_en = host_port_en;
		next_pci_boot_en = pci_boot_en;
		next_host_int_bit = host_int_bit;
		next_int_pending = cpu_int_pending;
		next_boot_done = boot_done;
		next_mem_wr.we = 1'b0;
		next_rom_req.req = 1'b0;
		// Set wins over clear only while the bit is clear; if the bit is already set, a clear in the same cycle drops the host event
		if (cpu_int_clear)
			next_host_int_bit = 1'b0;
		if (cpu_int_clear)
			next_int_pending = 1'b0;
		if (host_int_set && !host_int_bit)
		begin
			next_host_int_bit = 1'b1;
			// While stalled in host boot the event is not latched as pending
			if (!(state == boot_pkg::ST_HOST_WAIT))
				next_int_pending = 1'b1;
		end
		case (state)
			boot_pkg::ST_RESET:
			begin
				// Straps sampled once here, then frozen until reset
				next_straps.mode = boot_mode;
				next_straps.pci_sel = HAS_PCI ? pci_strap : 1'b0;
				next_stall = 1'b1;
				next_byte_cnt = boot_pkg::ROM_BASE;
				if (boot_mode == boot_pkg::MODE_HOST)
				begin
					next_state = boot_pkg::ST_HOST_WAIT;
					next_pci_boot_en = HAS_PCI ? pci_strap : 1'b0;
					next_host_port_en = !(HAS_PCI && pci_strap);
				end
				else if (boot_mode == boot_pkg::MODE_ROM)
				begin
					next_state = boot_pkg::ST_ROM_READ;
				end
				else
				begin
					next_state = boot_pkg::ST_RUN;
					next_stall = 1'b0;
					next_boot_done = 1'b1;
				end
			end
			boot_pkg::ST_HOST_WAIT:
			begin
				// Only host boot lets the interrupt bit end the stall
				if (host_int_set && !host_int_bit)
				begin
					next_stall = 1'b0;
					next_boot_done = 1'b1;
					next_state = boot_pkg::ST_RUN;
				end
			end
			boot_pkg::ST_ROM_READ:
			begin
				// One byte per request; the copy is self-started
				next_rom_req.req = 1'b1;
				next_rom_req.addr = byte_cnt;
				next_state = boot_pkg::ST_ROM_WAIT;
			end
			boot_pkg::ST_ROM_WAIT:
			begin
				if (rom_valid)
				begin
					if (byte_cnt[1:0] == 2'h3)
					begin
						next_mem_wr.we = 1'b1;
						next_mem_wr.addr = byte_cnt[boot_pkg::BYTE_AW-1:2];
						next_mem_wr.data = pack_word(pack, rom_data);
						next_state = boot_pkg::ST_ROM_WRITE;
					end
					else
					begin
						next_pack = {pack[15:0], rom_data};
						next_state = boot_pkg::ST_ROM_READ;
					end
					next_byte_cnt = byte_cnt + 10'h001;
				end
			end
			boot_pkg::ST_ROM_WRITE:
			begin
				// Counter wraps to zero after the last of the 1 KB
				if (byte_cnt == 10'h000)
				begin
					next_stall = 1'b0;
					next_boot_done = 1'b1;
					next_state = boot_pkg::ST_RUN;
				end
				else
					next_state = boot_pkg::ST_ROM_READ;
			end
			default:
			begin
				next_host_port_en = 1'b0;
			end
		endcase
	end

	// State registers; reset forces the defined stalled state
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state <= boot_pkg::ST_RESET;
			straps <= '0;
			rom_req <= '0;
			mem_wr <= '0;
			byte_cnt <= 10'h000;
			pack <= 24'h000000;
			cpu_stall <= 1'b1;
			host_port_en <= 1'b0;
			pci_boot_en <= 1'b0;
			host_int_bit <= 1'b0;
			cpu_int_pending <= 1'b0;
			boot_done <= 1'b0;
			cpu_start_addr <= boot_pkg::START_ADDR;
		end
		else
		begin
			state <= next_state;
			straps <= next_straps;
			rom_req <= next_rom_req;
			mem_wr <= next_mem_wr;
			byte_cnt <= next_byte_cnt;
			pack <= next_pack;
			cpu_stall <= next_stall;
			host_port_en <= next_host_port_en;
			pci_boot_en <= next_pci_boot_en;
			host_int_bit <= next_host_int_bit;
			cpu_int_pending <= next_int_pending;
			boot_done <= next_boot_done;
			cpu_start_addr <= boot_pkg::START_ADDR;
		end
	end

	// Count of word writes during the ROM copy
	logic [8:0] wr_cnt, next_wr_cnt;
	// Nine bits hold all 256 writes, so no saturation is needed
	always_comb
	begin
		next_wr_cnt = wr_cnt;
		if (mem_wr.we)
			next_wr_cnt = wr_cnt + 9'h001;
	end

	// Write counter register, cleared by every reset
	always_ff @(posedge mclk)
	begin
		if (rst)
			wr_cnt <= 9'h000;
		else
			wr_cnt <= next_wr_cnt;
	end

	// Release, strap, copy and interrupt bit checks: outside host boot only reset exit or a full copy

	no_release_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(cpu_stall) && straps.mode != boot_pkg::MODE_HOST
		|-> (straps.mode != boot_pkg::MODE_ROM
		&& $past(state) == boot_pkg::ST_RESET) || wr_cnt == 9'h100)
		else $error("stall released without host boot or full copy");
	host_release_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_HOST_WAIT && host_int_set && !host_int_bit
		|=> !cpu_stall && boot_done)
		else $error("host interrupt did not release stall");
	no_pending_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_HOST_WAIT && !cpu_int_clear
		|=> $stable(cpu_int_pending))
		else $error("boot interrupt recorded as pending");
	strap_hold_a: assert property (@(posedge mclk) disable iff (rst)
		state != boot_pkg::ST_RESET |=> $stable(straps))
		else $error("straps changed after capture");
	pci_select_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_HOST_WAIT
		|-> pci_boot_en == (HAS_PCI && straps.pci_sel)
		&& host_port_en != pci_boot_en)
		else $error("wrong host boot interface");
	rom_stall_a: assert property (@(posedge mclk) disable iff (rst)
		state inside {boot_pkg::ST_ROM_READ, boot_pkg::ST_ROM_WAIT}
		|-> cpu_stall)
		else $error("CPU ran during ROM copy");
	word_pack_a: assert property (@(posedge mclk) disable iff (rst)
		mem_wr.we |-> $past(byte_cnt[1:0]) == 2'h3 && $past(rom_valid))
		else $error("word written before four bytes");
	rom_done_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_ROM_WRITE && byte_cnt == 10'h000
		|=> !cpu_stall ##0 wr_cnt == 9'h100)
		else $error("stall not released after full copy");
	noboot_run_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_RESET && boot_mode == boot_pkg::MODE_NONE
		|=> !cpu_stall && cpu_start_addr == boot_pkg::START_ADDR)
		else $error("no-boot did not run at once");
	int_lock_a: assert property (@(posedge mclk) disable iff (rst)
		host_int_bit && !cpu_int_clear |=> host_int_bit)
		else $error("interrupt bit lost before clear");

	// Reset, mode entry, transfer shape and interrupt clear checks
	reset_state_a: assert property (@(posedge mclk)
		rst |=> cpu_stall && !boot_done && !rom_req.req && !mem_wr.we)
		else $error("reset state not applied");
	host_stall_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_HOST_WAIT |-> cpu_stall && !boot_done)
		else $error("CPU not stalled during host boot");
	host_access_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_HOST_WAIT |-> host_port_en || pci_boot_en)
		else $error("no host path to memory");
	rom_entry_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_RESET && boot_mode == boot_pkg::MODE_ROM
		|=> state == boot_pkg::ST_ROM_READ && cpu_stall)
		else $error("ROM boot did not start stalled");
	spare_code_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_RESET && boot_mode == 2'h3
		|=> state == boot_pkg::ST_RUN && !cpu_stall)
		else $error("spare boot code did not run at once");
	read_order_a: assert property (@(posedge mclk) disable iff (rst)
		rom_req.req |-> rom_req.addr == byte_cnt ##1 !rom_req.req)
		else $error("ROM read out of order");
	write_pulse_a: assert property (@(posedge mclk) disable iff (rst)
		mem_wr.we |=> !mem_wr.we)
		else $error("word write held over");
	run_state_a: assert property (@(posedge mclk) disable iff (rst)
		state == boot_pkg::ST_RUN |-> !cpu_stall && boot_done)
		else $error("running state still stalled");
	int_clear_a: assert property (@(posedge mclk) disable iff (rst)
		cpu_int_clear && !host_int_set |=> !host_int_bit && !cpu_int_pending)
		else $error("interrupt clear not applied");
endmodule

/* File: tb/rom_model.sv */
/*
 Byte-wide boot ROM on the memory interface, one outstanding read.
 Assumes requests are one-cycle pulses; slow adds wait cycles.
*/
`timescale 1ns/100ps
module rom_model (
	input wire logic mclk,
	input wire boot_pkg::rom_req_t rom_req,
	input wire logic slow,
	output logic rom_valid,
	output logic [7:0] rom_data
);
	logic [9:0] addr = 10'h000;
	logic busy = 1'b0;
	int wait_left = 0;
	initial rom_valid = 1'b0;
	initial rom_data = 8'h00;
	// Answer after a delay; bus churns when idle so stale bytes never match
	always @(posedge mclk)
	begin
		rom_valid <= 1'b0;
		rom_data <= ~rom_data;
		if (rom_req.req === 1'b1)
		begin
			busy <= 1'b1;
			addr <= rom_req.addr;
			wait_left <= slow ? 3 : 0;
		end
		else if (busy && wait_left == 0)
		begin
			busy <= 1'b0;
			rom_valid <= 1'b1;
			rom_data <= addr[7:0] ^ 8'hA5 ^ {6'h00, addr[9:8]};
		end
		else if (busy)
			wait_left <= wait_left - 1;
	end
endmodule

/* File: tb/tb.sv */
/*
 Self-checking bench for the boot mode controller with a ROM model.
 Assumes the package encodings and a little-endian image build.
*/
`timescale 1ns/100ps
module tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] boot_mode = 2'h0;
	logic pci_strap = 1'b0;
	logic host_int_set = 1'b0;
	logic cpu_int_clear = 1'b0;
	logic rom_valid, slow = 1'b0, cpu_stall, host_port_en, pci_boot_en;
	logic host_int_bit, cpu_int_pending, boot_done;
	logic [7:0] rom_data;
	logic [31:0] cpu_start_addr;
	boot_pkg::rom_req_t rom_req;
	boot_pkg::mem_wr_t mem_wr;
	int num_errors = 0, checks_done = 0, cyc = 0, nw = 0, nb = 0, i;
	// mode, pci, stall, host port, pci boot, done
	logic [6:0] rows [5] = '{7'h48, 7'h2C, 7'h3A, 7'h71, 7'h01};
	always #20 mclk = ~mclk;
	boot_mode_controller u_boot_mode_controller (.mclk(mclk), .rst(rst),
		.boot_mode(boot_mode), .pci_strap(pci_strap),
		.host_int_set(host_int_set), .cpu_int_clear(cpu_int_clear),
		.rom_valid(rom_valid), .rom_data(rom_data), .rom_req(rom_req),
		.mem_wr(mem_wr), .cpu_stall(cpu_stall),
		.cpu_start_addr(cpu_start_addr), .host_port_en(host_port_en),
		.pci_boot_en(pci_boot_en), .host_int_bit(host_int_bit),
		.cpu_int_pending(cpu_int_pending), .boot_done(boot_done));
	rom_model u_rom_model (.mclk(mclk), .rom_req(rom_req), .slow(slow),
		.rom_valid(rom_valid), .rom_data(rom_data));
	function automatic logic [7:0] rb(input logic [9:0] a);
		return a[7:0] ^ 8'hA5 ^ {6'h00, a[9:8]};
	endfunction
	// Expected word: first byte of the group in the low lane
	function automatic logic [31:0] ew(input int w);
		return {rb(10'(4*w+3)), rb(10'(4*w+2)),
			rb(10'(4*w+1)), rb(10'(4*w))};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Reset held 10 cycles with a running clock, then released
	task reset_to(input logic [1:0] m, input logic p);
		@(posedge mclk) rst <= 1'b1;
		boot_mode <= m;
		pci_strap <= p;
		repeat (9) @(posedge mclk);
		#1 chk(cpu_stall, 1);
		chk(boot_done, 0);
		@(posedge mclk) rst <= 1'b0;
		@(posedge mclk);
		#1;
	endtask
	// One-cycle request from host or CPU, sampled a cycle after it is taken
	task pulse(input bit clr);
		@(posedge mclk) if (clr) cpu_int_clear <= 1'b1;
		else host_int_set <= 1'b1;
		@(posedge mclk) cpu_int_clear <= 1'b0;
		host_int_set <= 1'b0;
		@(posedge mclk);
		#1;
	endtask
	// Word and byte order watched on the fly; slow alternates per word
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			num_errors++;
			report_and_stop;
		end
		if (rst === 1'b1)
		begin
			nw = 0;
			nb = 0;
		end
		if (rom_req.req === 1'b1)
		begin
			chk({22'h0, rom_req.addr}, boot_pkg::ROM_BASE + nb);
			nb++;
		end
		if (mem_wr.we === 1'b1)
		begin
			chk({24'h0, mem_wr.addr}, nw);
			chk(mem_wr.data, ew(nw));
			chk(cpu_stall, 1);
			nw++;
			slow <= nw[0];
		end
	end
	initial
	begin
		for (i = 0; i < 5; i++)
		begin
			reset_to(rows[i][6:5], rows[i][4]);
			chk({28'h0, cpu_stall, host_port_en, pci_boot_en, boot_done},
				{28'h0, rows[i][3:0]});
			chk(cpu_start_addr, boot_pkg::START_ADDR);
		end
		$display("strap rows done");
		reset_to(boot_pkg::MODE_HOST, 1'b0);
		repeat (6) @(posedge mclk);
		#1 chk(cpu_stall, 1);
		@(posedge mclk) boot_mode <= boot_pkg::MODE_NONE;
		pulse(0);
		chk(cpu_stall, 0);
		chk(host_int_bit, 1);
		chk(cpu_int_pending, 0);
		pulse(0);
		chk(cpu_int_pending, 0);
		pulse(1);
		chk(host_int_bit, 0);
		$display("host boot done");
		reset_to(boot_pkg::MODE_ROM, 1'b0);
		pulse(0);
		chk(cpu_stall, 1);
		chk(cpu_int_pending, 1);
		pulse(1);
		chk(cpu_int_pending, 0);
		for (i = 0; i < 20000 && cpu_stall !== 1'b0; i++)
			@(posedge mclk);
		#1 chk(nw, boot_pkg::ROM_WORDS);
		chk(boot_done, 1);
		chk(cpu_start_addr, boot_pkg::START_ADDR);
		$display("rom boot done");
		report_and_stop;
	end
endmodule
